// File: rtl/ccp_pkg.sv
package ccp_pkg;
	// byte addresses on the plain register port
	localparam logic [7:0] ADDR_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_ENABLES = 8'h8C;
	localparam logic [7:0] ADDR_A_LOW = 8'h15;
	localparam logic [7:0] ADDR_A_HIGH = 8'h16;
	localparam logic [7:0] ADDR_A_CTRL = 8'h17;
	localparam logic [7:0] ADDR_B_LOW = 8'h1B;
	localparam logic [7:0] ADDR_B_HIGH = 8'h1C;
	localparam logic [7:0] ADDR_B_CTRL = 8'h1D;
	// flag and enable bit positions
	localparam int FLAG_A_POS = 2;
	localparam int FLAG_B_POS = 0;
	localparam int FLAG_T2_POS = 1;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] ENABLES_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_MASK = 8'h3F;
	// mode_select field codes
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLR = 4'h9;
	localparam logic [3:0] MODE_CMP_SWI = 4'hA;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
	localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
	localparam logic [3:0] PRESCALE_16_LAST = 4'hF;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [1:0] spare;
		logic duty_lsb_high;
		logic duty_lsb_low;
		logic [3:0] mode_select;
	} unit_ctrl_t;
endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; level changes once stages two and three agree
module pin_sync (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic pin_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);
	logic [2:0] sync_r;
	logic level_r;
	wire agree = (sync_r[1] == sync_r[2]);
	wire level_nxt = agree ? sync_r[2] : level_r;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_r <= 3'h0;
			level_r <= 1'b0;
		end else begin
			sync_r <= {sync_r[1:0], pin_i};
			level_r <= level_nxt;
		end
	end

	assign level_o = level_r;
	assign rise_o = level_nxt & ~level_r;
	assign fall_o = ~level_nxt & level_r;
endmodule

// File: rtl/ccp_unit.sv
`timescale 1ns/1ps
// one capture/compare/pwm unit; value register lives in the top
module ccp_unit (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire ccp_pkg::unit_ctrl_t ctrl_i,
	input wire logic ctrl_wr_i,
	input wire logic [15:0] value_i,
	input wire logic [15:0] timebase_sixteen_i,
	input wire logic [7:0] pwm_timebase_i,
	input wire logic pwm_period_i,
	input wire logic pin_rise_i,
	input wire logic pin_fall_i,
	output logic capture_o,
	output logic match_o,
	output logic special_o,
	output logic out_o
);
	logic [3:0] presc_r;
	logic out_r;
	logic [9:0] duty_r;
	logic prev_eq_r;
	logic [3:0] presc_nxt;
	logic out_nxt;
	wire [3:0] mode = ctrl_i.mode_select;
	wire is_cap = (mode[3:2] == 2'b01);
	wire is_cmp = (mode[3:2] == 2'b10);
	wire is_pwm = (mode[3:2] == 2'b11);
	wire edge_rise = pin_rise_i;
	wire eq = is_cmp && (value_i == timebase_sixteen_i);
	wire hit = eq & ~prev_eq_r; // one event per match, not per cycle held
	wire [3:0] last = (mode == ccp_pkg::MODE_CAP_RISE16) ? ccp_pkg::PRESCALE_16_LAST
		: ccp_pkg::PRESCALE_4_LAST;
	wire scaled = (mode == ccp_pkg::MODE_CAP_RISE4) || (mode == ccp_pkg::MODE_CAP_RISE16);
	wire cap_evt = is_cap && ((mode == ccp_pkg::MODE_CAP_FALL) ? pin_fall_i
		: (scaled ? (edge_rise && presc_r == last) : edge_rise));
	// pwm compares ten duty bits against timer2 extended by two constant zero bits
	wire [9:0] pwm_count = {pwm_timebase_i, 2'b00};

	always_comb begin
		presc_nxt = presc_r;
		if (!is_cap || ctrl_wr_i) begin
			presc_nxt = 4'h0;
		end else if (scaled && edge_rise) begin
			presc_nxt = (presc_r == last) ? 4'h0 : presc_r + 4'h1;
		end
		out_nxt = out_r;
		// keyed on the stored mode, since the write strobe still sees the old control byte
		if (mode == ccp_pkg::MODE_OFF) begin
			out_nxt = 1'b0;
		end else if (is_pwm) begin
			out_nxt = (pwm_count < duty_r);
		end else if (hit && mode == ccp_pkg::MODE_CMP_SET) begin
			out_nxt = 1'b1;
		end else if (hit && mode == ccp_pkg::MODE_CMP_CLR) begin
			out_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			presc_r <= 4'h0;
			out_r <= 1'b0;
			duty_r <= 10'h000;
			prev_eq_r <= 1'b0;
		end else begin
			presc_r <= presc_nxt;
			out_r <= out_nxt;
			prev_eq_r <= eq;
			// both units latch duty on the shared timer2 period edge
			if (pwm_period_i) begin
				duty_r <= {value_i[7:0], ctrl_i.duty_lsb_high, ctrl_i.duty_lsb_low};
			end
		end
	end

	assign capture_o = cap_evt;
	assign match_o = hit;
	assign special_o = hit && (mode == ccp_pkg::MODE_CMP_SPECIAL);
	assign out_o = out_r;
endmodule

// File: rtl/dual_capture_compare_pwm.sv
`timescale 1ns/1ps
// Overview of operation
// - each unit holds one 16-bit value used as capture, compare or pwm duty value.
// - the value is reached as separate low and high bytes, and a control byte sets the mode.
// - both units behave alike except for the special event trigger action.
// - the first unit's special event match clears the sixteen-bit timebase.
// - the second unit's special event match clears the timebase and starts a conversion if enabled.
// - capture and compare use the sixteen-bit timebase, pwm uses the pwm timebase.
// - both pwm units share one period and update instant from the pwm timebase period match.
// - in capture mode the selected pin edge copies the timebase into the value and sets the flag.
// - in compare mode equality drives the output high, low or leaves it, and sets the flag.
// - writing zero to the control byte forces the compare output low.
// - the capture prescaler is cleared when off, when not capturing and on reset.
module dual_capture_compare_pwm (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [15:0] timebase_sixteen_i,
	input wire logic [7:0] pwm_timebase_i,
	input wire logic pwm_period_match_i,
	input wire logic converter_enabled_i,
	input wire logic event_pin_a_i,
	input wire logic event_pin_b_i,
	output logic unit_a_out_o,
	output logic unit_b_out_o,
	output logic timebase_clear_o,
	output logic convert_start_o,
	output logic irq_o
);
	ccp_pkg::reg_req_t req;
	ccp_pkg::unit_ctrl_t ctrl_a_r;
	ccp_pkg::unit_ctrl_t ctrl_b_r;
	logic [15:0] value_a_r;
	logic [15:0] value_b_r;
	logic [7:0] flags_r;
	logic [7:0] enables_r;
	logic [7:0] rdata_r;
	logic tclr_r;
	logic conv_r;
	logic irq_r;
	logic rise_a;
	logic fall_a;
	logic rise_b;
	logic fall_b;
	logic cap_a;
	logic cap_b;
	logic match_a;
	logic match_b;
	logic spec_a;
	logic spec_b;
	logic out_a;
	logic out_b;

	function automatic logic hit(input ccp_pkg::reg_req_t r, input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
	wire wr_flags = hit(req, ccp_pkg::ADDR_FLAGS);
	wire wr_enables = hit(req, ccp_pkg::ADDR_ENABLES);
	wire wr_a_low = hit(req, ccp_pkg::ADDR_A_LOW);
	wire wr_a_high = hit(req, ccp_pkg::ADDR_A_HIGH);
	wire wr_a_ctrl = hit(req, ccp_pkg::ADDR_A_CTRL);
	wire wr_b_low = hit(req, ccp_pkg::ADDR_B_LOW);
	wire wr_b_high = hit(req, ccp_pkg::ADDR_B_HIGH);
	wire wr_b_ctrl = hit(req, ccp_pkg::ADDR_B_CTRL);

	pin_sync sync_a (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.pin_i(event_pin_a_i),
		.level_o(),
		.rise_o(rise_a),
		.fall_o(fall_a)
	);

	pin_sync sync_b (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.pin_i(event_pin_b_i),
		.level_o(),
		.rise_o(rise_b),
		.fall_o(fall_b)
	);

	ccp_unit first_unit (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ctrl_i(ctrl_a_r),
		.ctrl_wr_i(wr_a_ctrl),
		.value_i(value_a_r),
		.timebase_sixteen_i(timebase_sixteen_i),
		.pwm_timebase_i(pwm_timebase_i),
		.pwm_period_i(pwm_period_match_i),
		.pin_rise_i(rise_a),
		.pin_fall_i(fall_a),
		.capture_o(cap_a),
		.match_o(match_a),
		.special_o(spec_a),
		.out_o(out_a)
	);

	ccp_unit second_unit (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ctrl_i(ctrl_b_r),
		.ctrl_wr_i(wr_b_ctrl),
		.value_i(value_b_r),
		.timebase_sixteen_i(timebase_sixteen_i),
		.pwm_timebase_i(pwm_timebase_i),
		.pwm_period_i(pwm_period_match_i),
		.pin_rise_i(rise_b),
		.pin_fall_i(fall_b),
		.capture_o(cap_b),
		.match_o(match_b),
		.special_o(spec_b),
		.out_o(out_b)
	);

	// events: capture or compare match of each unit, plus the pwm period match
	wire [7:0] evt = (8'((cap_a | match_a)) << ccp_pkg::FLAG_A_POS)
		| (8'((cap_b | match_b)) << ccp_pkg::FLAG_B_POS)
		| (8'(pwm_period_match_i) << ccp_pkg::FLAG_T2_POS);
	// write one to clear; a same-cycle event wins over the clear
	wire [7:0] flags_nxt = (flags_r & ~(wr_flags ? wdata_i : 8'h00)) | evt;
	wire [7:0] rd_mux = (addr_i == ccp_pkg::ADDR_FLAGS) ? flags_r
		: (addr_i == ccp_pkg::ADDR_ENABLES) ? enables_r
		: (addr_i == ccp_pkg::ADDR_A_LOW) ? value_a_r[7:0]
		: (addr_i == ccp_pkg::ADDR_A_HIGH) ? value_a_r[15:8]
		: (addr_i == ccp_pkg::ADDR_A_CTRL) ? ctrl_a_r
		: (addr_i == ccp_pkg::ADDR_B_LOW) ? value_b_r[7:0]
		: (addr_i == ccp_pkg::ADDR_B_HIGH) ? value_b_r[15:8]
		: (addr_i == ccp_pkg::ADDR_B_CTRL) ? ctrl_b_r : 8'h00;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_a_r <= ccp_pkg::CTRL_RESET;
			ctrl_b_r <= ccp_pkg::CTRL_RESET;
			flags_r <= ccp_pkg::FLAGS_RESET;
			enables_r <= ccp_pkg::ENABLES_RESET;
			rdata_r <= 8'h00;
		end else begin
			if (wr_a_ctrl) begin
				ctrl_a_r <= wdata_i & ccp_pkg::CTRL_MASK;
			end
			if (wr_b_ctrl) begin
				ctrl_b_r <= wdata_i & ccp_pkg::CTRL_MASK;
			end
			if (wr_enables) begin
				enables_r <= wdata_i;
			end
			flags_r <= flags_nxt;
			rdata_r <= rd_i ? rd_mux : 8'h00;
		end
	end

	// value registers clear on reset; capture overrides a same-cycle byte write
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			value_a_r <= 16'h0000;
			value_b_r <= 16'h0000;
		end else begin
			if (cap_a) begin
				value_a_r <= timebase_sixteen_i;
			end else if (wr_a_low) begin
				value_a_r[7:0] <= wdata_i;
			end else if (wr_a_high) begin
				value_a_r[15:8] <= wdata_i;
			end
			if (cap_b) begin
				value_b_r <= timebase_sixteen_i;
			end else if (wr_b_low) begin
				value_b_r[7:0] <= wdata_i;
			end else if (wr_b_high) begin
				value_b_r[15:8] <= wdata_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tclr_r <= 1'b0;
			conv_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			tclr_r <= spec_a | spec_b;
			conv_r <= spec_b & converter_enabled_i;
			irq_r <= |(flags_nxt & enables_r);
		end
	end

	assign rdata_o = rdata_r;
	assign unit_a_out_o = out_a;
	assign unit_b_out_o = out_b;
	assign timebase_clear_o = tclr_r;
	assign convert_start_o = conv_r;
	assign irq_o = irq_r;
endmodule

// File: testbench/timer_model.sv
`timescale 1ns/1ps
// timers beside the units; timer2 wraps early so period events come often
module timer_model #(parameter logic [7:0] PERIOD = 8'h3F) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	output logic [15:0] t1_o,
	output logic [7:0] t2_o,
	output logic period_o
);
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			t1_o <= 16'h0000;
			t2_o <= 8'h00;
			period_o <= 1'b0;
		end else begin
			t1_o <= clear_i ? 16'h0000 : t1_o + 16'h0001;
			t2_o <= (t2_o == PERIOD) ? 8'h00 : t2_o + 8'h01;
			period_o <= (t2_o == PERIOD);
		end
	end
endmodule

// File: testbench/dual_capture_compare_pwm_monitor.sv
`timescale 1ns/1ps
module ccp_monitor (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic converter_enabled_i,
	input wire logic unit_a_out_o,
	input wire logic unit_b_out_o,
	input wire logic timebase_clear_o,
	input wire logic convert_start_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	conv_clear_a: assert property (convert_start_o |-> timebase_clear_o)
		else $error("conversion start without timer clear");
	conv_enable_a: assert property (convert_start_o |-> $past(converter_enabled_i))
		else $error("conversion start while converter disabled");
	clear_pulse_a: assert property (timebase_clear_o |=> !timebase_clear_o)
		else $error("timer clear longer than one cycle");
	conv_pulse_a: assert property (convert_start_o |=> !convert_start_o)
		else $error("conversion start longer than one cycle");
	rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read answer");
	unmapped_read_a: assert property (rd_i && addr_i == 8'hFF |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	ctrl_spare_a: assert property (rd_i && addr_i == ccp_pkg::ADDR_A_CTRL
		|=> rdata_o[7:6] == 2'b00)
		else $error("control spare bits not zero");
	out_a_zero_a: assert property (wr_i && addr_i == ccp_pkg::ADDR_A_CTRL
		&& wdata_i == 8'h00 |-> ##[1:2] !unit_a_out_o)
		else $error("first output not forced low");
	out_b_zero_a: assert property (wr_i && addr_i == ccp_pkg::ADDR_B_CTRL
		&& wdata_i == 8'h00 |-> ##[1:2] !unit_b_out_o)
		else $error("second output not forced low");
endmodule
bind dual_capture_compare_pwm ccp_monitor mon (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.converter_enabled_i(converter_enabled_i), .unit_a_out_o(unit_a_out_o),
	.unit_b_out_o(unit_b_out_o), .timebase_clear_o(timebase_clear_o),
	.convert_start_o(convert_start_o));

// File: testbench/dual_capture_compare_pwm_tb_top.sv
`timescale 1ns/1ps
module dual_capture_compare_pwm_tb_top;
	logic clk_sys_i, rst_n_i, wr_i, rd_i, conv_en, pin_a, pmatch, out_a, out_b, tclear, conv, irq;
	logic [7:0] addr_i, wdata_i, rdata_o, rv, t2;
	logic [15:0] t1, tcap, cap, prev;
	int fails, checked, n, k;
	timer_model tm (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clear_i(tclear), .t1_o(t1),
		.t2_o(t2), .period_o(pmatch));
	dual_capture_compare_pwm dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timebase_sixteen_i(t1),
		.pwm_timebase_i(t2), .pwm_period_match_i(pmatch), .converter_enabled_i(conv_en),
		.event_pin_a_i(pin_a), .event_pin_b_i(1'b0), .unit_a_out_o(out_a), .unit_b_out_o(out_b),
		.timebase_clear_o(tclear), .convert_start_o(conv), .irq_o(irq));
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic rd_a(output logic [15:0] v);
		rd(ccp_pkg::ADDR_A_LOW, v[7:0]);
		rd(ccp_pkg::ADDR_A_HIGH, v[15:8]);
	endtask
	function automatic logic pick(input int sel);
		pick = (sel == 0) ? tclear : ((sel == 1) ? conv : out_a);
	endfunction
	// bounded wait so a dead output cannot hang the run; sel 0 clear, 1 convert, 2 output a
	task automatic wait_for(input int sel, input logic v);
		n = 0;
		while (pick(sel) !== v && n < 1000) begin
			@(posedge clk_sys_i);
			#1 n++;
		end
		chk(16'(n < 1000), 16'h0001);
	endtask
	task automatic pulse_a();
		pin_a <= 1'b1;
		#1 tcap = t1;
		repeat (6) @(posedge clk_sys_i);
		pin_a <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#400us;
		fails++;
		wrap_up();
	end
	initial begin
		wr_i = 1'b0;
		rd_i = 1'b0;
		conv_en = 1'b0;
		pin_a = 1'b0;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		rst_n_i = 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(ccp_pkg::ADDR_FLAGS, rv);
		chk({8'h00, rv}, {8'h00, ccp_pkg::FLAGS_RESET});
		rd(ccp_pkg::ADDR_ENABLES, rv);
		chk({8'h00, rv}, {8'h00, ccp_pkg::ENABLES_RESET});
		rd(ccp_pkg::ADDR_A_CTRL, rv);
		chk({8'h00, rv}, {8'h00, ccp_pkg::CTRL_RESET});
		wr(ccp_pkg::ADDR_B_CTRL, 8'hFF);
		rd(ccp_pkg::ADDR_B_CTRL, rv);
		chk({8'h00, rv}, {8'h00, ccp_pkg::CTRL_MASK});
		wr(ccp_pkg::ADDR_B_CTRL, 8'h00);
		rd(8'hFF, rv);
		chk({8'h00, rv}, 16'h0000);
		wr(ccp_pkg::ADDR_A_LOW, 8'h23);
		wr(ccp_pkg::ADDR_A_HIGH, 8'h01);
		rd_a(cap);
		chk(cap, 16'h0123);
		wr(ccp_pkg::ADDR_ENABLES, 8'h05);
		wr(ccp_pkg::ADDR_A_CTRL, 8'h0B);
		wait_for(0, 1'b1);
		chk({15'h0000, irq}, 16'h0001);
		wr(ccp_pkg::ADDR_A_CTRL, 8'h00);
		rd(ccp_pkg::ADDR_FLAGS, rv);
		chk({8'h00, rv & 8'h07}, 16'h0006);
		wr(ccp_pkg::ADDR_FLAGS, 8'h07);
		@(posedge clk_sys_i);
		#1 chk({15'h0000, irq}, 16'h0000);
		conv_en <= 1'b1;
		wr(ccp_pkg::ADDR_B_LOW, 8'h30);
		wr(ccp_pkg::ADDR_B_HIGH, 8'h00);
		wr(ccp_pkg::ADDR_B_CTRL, 8'h0B);
		wait_for(1, 1'b1);
		conv_en <= 1'b0;
		k = 0;
		repeat (120) begin
			@(posedge clk_sys_i);
			#1 k += int'(conv);
		end
		chk(16'(k), 16'h0000);
		// unit b keeps clearing timer1 so unit a matches soon
		wr(ccp_pkg::ADDR_A_LOW, 8'h10);
		wr(ccp_pkg::ADDR_A_HIGH, 8'h00);
		wr(ccp_pkg::ADDR_A_CTRL, 8'h08);
		wait_for(2, 1'b1);
		wr(ccp_pkg::ADDR_A_CTRL, 8'h09);
		wait_for(2, 1'b0);
		wr(ccp_pkg::ADDR_A_CTRL, 8'h08);
		wait_for(2, 1'b1);
		wr(ccp_pkg::ADDR_A_CTRL, 8'h00);
		@(posedge clk_sys_i);
		#1 chk({15'h0000, out_a}, 16'h0000);
		wr(ccp_pkg::ADDR_FLAGS, 8'h07);
		wr(ccp_pkg::ADDR_A_CTRL, 8'h0A);
		repeat (120) @(posedge clk_sys_i);
		#1 chk({15'h0000, out_a}, 16'h0000);
		rd(ccp_pkg::ADDR_FLAGS, rv);
		chk({8'h00, rv & 8'h04}, 16'h0004);
		wr(ccp_pkg::ADDR_B_CTRL, 8'h00);
		wr(ccp_pkg::ADDR_A_CTRL, 8'h05);
		wr(ccp_pkg::ADDR_FLAGS, 8'h07);
		pulse_a();
		rd_a(cap);
		chk(16'((cap - tcap) > 16'h0000 && (cap - tcap) < 16'h0008), 16'h0001);
		rd(ccp_pkg::ADDR_FLAGS, rv);
		chk({8'h00, rv & 8'h04}, 16'h0004);
		// leave the prescaler part-way, then pass through off so it must restart at zero
		wr(ccp_pkg::ADDR_A_CTRL, 8'h06);
		repeat (2) pulse_a();
		wr(ccp_pkg::ADDR_A_CTRL, 8'h00);
		wr(ccp_pkg::ADDR_A_CTRL, 8'h06);
		prev = cap;
		repeat (3) pulse_a();
		rd_a(cap);
		chk(cap, prev);
		pulse_a();
		rd_a(cap);
		chk(16'((cap - tcap) < 16'h0008), 16'h0001);
		// falling-edge capture lands a few cycles after the pin drops, six after it rose
		wr(ccp_pkg::ADDR_A_CTRL, 8'h04);
		pulse_a();
		rd_a(cap);
		chk(16'((cap - tcap) > 16'h0006 && (cap - tcap) < 16'h000E), 16'h0001);
		// duty 0x08 in the low byte is 32 quarter counts: 8 of every 64 timer2 counts high
		wr(ccp_pkg::ADDR_B_LOW, 8'h08);
		wr(ccp_pkg::ADDR_B_CTRL, 8'h0C);
		repeat (70) @(posedge clk_sys_i);
		k = 0;
		repeat (128) begin
			@(posedge clk_sys_i);
			#1 k += int'(out_b);
		end
		chk(16'(k), 16'h0010);
		wr(ccp_pkg::ADDR_B_CTRL, 8'h00);
		@(posedge clk_sys_i);
		#1 chk({15'h0000, out_b}, 16'h0000);
		wrap_up();
	end
endmodule
